/* rtl/pressure_temp_measure_seq.v */
// Measurement sequencer: power modes, conversions, filtering and register port
// Behaviour
// R01: Sleep mode starts no conversions
// R02: Normal mode alternates measuring and standby forever
// R03: Forced mode measures once, returns to sleep
// R04: Reset restores defaults, sleep mode
// R05: Period converts temperature, pressure, then filters
// R06: Pressure oversampling gives 16 to 20 bits
// R07: Skipped pressure reads 0x80000
// R08: Temperature codes: skip, x1..x8, 101+ x16
// R09: Temperature width 16 to 20 bits
// R10: Skipped temperature reads 0x80000
// R11: Filter: (old*(c-1)+new)/c
// R12: Filter selector: off, 2, 4, 8, 16
// R13: Step response 75% after 1/2/5/11/22
// R14: Filter write resets filter memory
// R15: Skipped channel keeps its filter memory
// R16: Re-enabled channel filters against kept memory
// R17: Mode field: 00 sleep, 01/10 forced, 11 normal
// R18: Standby codes 0.5 ms to 4000 ms
// R19: Mode change waits period end, extras ignored
// R20: Pressure codes same as temperature codes
// R21: Filter codes above 011 mean 16
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defines.vh"
module pressure_temp_measure_seq #(
  parameter integer CLK_MHZ = `CLK_MHZ,
  parameter integer STBY_0_CYC = `STBY_0_US * `CLK_MHZ,
  parameter integer STBY_1_CYC = `STBY_1_US * `CLK_MHZ,
  parameter integer STBY_2_CYC = `STBY_2_US * `CLK_MHZ,
  parameter integer STBY_3_CYC = `STBY_3_US * `CLK_MHZ,
  parameter integer STBY_4_CYC = `STBY_4_US * `CLK_MHZ,
  parameter integer STBY_5_CYC = `STBY_5_US * `CLK_MHZ,
  parameter integer STBY_6_CYC = `STBY_6_US * `CLK_MHZ,
  parameter integer STBY_7_CYC = `STBY_7_US * `CLK_MHZ,
  parameter integer CONV_BASE_CYC = `CONV_BASE_US * `CLK_MHZ,
  parameter integer CONV_OSR_CYC = `CONV_PER_OSR_US * `CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [19:0] adc_press,
  input wire [19:0] adc_temp,
  output reg conv_temp_active,
  output reg conv_press_active,
  output reg measuring
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_TEMP = 2'd1;
  localparam [1:0] ST_PRESS = 2'd2;
  localparam [1:0] ST_STBY = 2'd3;
  // Period runs TEMP then PRESS; a skipped channel still passes through
  // its state for one cycle, so both results update together at period end.
  // Standby only exists in normal mode; other modes return to IDLE.

  reg [7:0] ctrl_r;
  reg [7:0] config_r;
  reg [1:0] mode_r;
  reg [1:0] pend_mode_r;
  reg pend_r;
  reg [1:0] state_r;
  reg [31:0] cnt_r;
  reg filt_upd_r;
  reg filt_rst_r;
  reg [19:0] raw_p_r;
  reg [19:0] raw_t_r;
  reg [31:0] stby_cyc;
  reg [31:0] osr_cyc_t;
  reg [31:0] osr_cyc_p;
  wire [2:0] osr_t = ctrl_r[7:5];
  wire [2:0] osr_p = ctrl_r[4:2];
  wire [2:0] filt_sel = config_r[4:2];
  wire [2:0] stby_sel = config_r[7:5];
  wire [19:0] press_res;
  wire [19:0] temp_res;
  wire busy = (state_r == ST_TEMP) || (state_r == ST_PRESS);
  wire [1:0] wr_mode = reg_wdata[1:0];

  // Conversion length grows with oversampling count
  function [31:0] osr_len;
    input [2:0] code;
    begin
      case (code)
        3'b000: osr_len = 32'd0;
        3'b001: osr_len = CONV_BASE_CYC + CONV_OSR_CYC;
        3'b010: osr_len = CONV_BASE_CYC + 2 * CONV_OSR_CYC;
        3'b011: osr_len = CONV_BASE_CYC + 4 * CONV_OSR_CYC;
        3'b100: osr_len = CONV_BASE_CYC + 8 * CONV_OSR_CYC;
        default: osr_len = CONV_BASE_CYC + 16 * CONV_OSR_CYC;
      endcase
    end
  endfunction

  always @* begin
    osr_cyc_t = osr_len(osr_t);
    osr_cyc_p = osr_len(osr_p);
    case (stby_sel)
      3'b000: stby_cyc = STBY_0_CYC; // [R18]
      3'b001: stby_cyc = STBY_1_CYC;
      3'b010: stby_cyc = STBY_2_CYC;
      3'b011: stby_cyc = STBY_3_CYC;
      3'b100: stby_cyc = STBY_4_CYC;
      3'b101: stby_cyc = STBY_5_CYC;
      3'b110: stby_cyc = STBY_6_CYC;
      default: stby_cyc = STBY_7_CYC;
    endcase
  end

  // Register writes and mode handling
  // Oversampling bits are stored at once even while busy; a write during TEMP already sets
  // the pressure count, loaded when TEMP ends, and the filters read both codes at period end.
  // A pending mode change blocks new periods until it has been applied.
  always @(posedge clk) begin
    if (sys_rst) begin // [R04]
      ctrl_r <= `CTRL_RST;
      config_r <= `CONFIG_RST;
      mode_r <= `MODE_SLEEP;
      pend_mode_r <= `MODE_SLEEP;
      pend_r <= 1'b0;
      filt_rst_r <= 1'b0;
    end else begin
      filt_rst_r <= 1'b0;
      if (reg_wr && reg_addr == `ADDR_CONFIG) begin
        config_r <= reg_wdata;
        filt_rst_r <= 1'b1; // [R14]
      end
      if (reg_wr && reg_addr == `ADDR_CTRL_MEAS) begin
        ctrl_r[7:2] <= reg_wdata[7:2];
        if (busy) begin
          // Only the first change during a period is held; later ones dropped
          if (!pend_r) begin // [R19]
            pend_r <= 1'b1;
            pend_mode_r <= wr_mode;
          end
        end else if (!pend_r) begin
          mode_r <= wr_mode; // [R17]
        end
      end
      if (pend_r && !busy) begin
        pend_r <= 1'b0;
        mode_r <= pend_mode_r; // [R19]
      end else if (state_r == ST_PRESS && cnt_r == 32'd0 && !pend_r &&
                   mode_r != `MODE_NORMAL && mode_r != `MODE_SLEEP &&
                   !(reg_wr && reg_addr == `ADDR_CTRL_MEAS)) begin
        mode_r <= `MODE_SLEEP; // [R03]
      end
    end
  end

  // Measurement period sequencer
  // Counters are wide enough for the longest standby at the default clock
  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 32'd0;
      filt_upd_r <= 1'b0;
      raw_p_r <= 20'h0_0000;
      raw_t_r <= 20'h0_0000;
    end else begin
      filt_upd_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (mode_r != `MODE_SLEEP && !pend_r) begin // [R01]
            state_r <= ST_TEMP;
            cnt_r <= osr_cyc_t;
          end
        end
        ST_TEMP: begin
          if (cnt_r != 32'd0) begin
            cnt_r <= cnt_r - 32'd1;
          end else begin
            raw_t_r <= adc_temp; // [R05]
            state_r <= ST_PRESS;
            cnt_r <= osr_cyc_p;
          end
        end
        ST_PRESS: begin
          if (cnt_r != 32'd0) begin
            cnt_r <= cnt_r - 32'd1;
          end else begin
            raw_p_r <= adc_press;
            filt_upd_r <= 1'b1; // [R05]
            if (mode_r == `MODE_NORMAL) begin
              state_r <= ST_STBY; // [R02]
              cnt_r <= stby_cyc;
            end else begin
              state_r <= ST_IDLE; // [R03]
            end
          end
        end
        ST_STBY: begin
          if (mode_r != `MODE_NORMAL) begin
            state_r <= ST_IDLE;
          end else if (cnt_r != 32'd0) begin
            cnt_r <= cnt_r - 32'd1;
          end else begin
            state_r <= ST_TEMP; // [R02]
            cnt_r <= osr_cyc_t;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Skipped channel: osr code 000 keeps memory, output shows fixed value
  iir_channel u_press (
    .clk(clk),
    .sys_rst(sys_rst),
    .osr_sel(osr_p),
    .filt_sel(filt_sel),
    .filt_reset(filt_rst_r),
    .update(filt_upd_r),
    .raw_in(raw_p_r),
    .result_r(press_res)
  ); // [R15] [R07] [R06]

  iir_channel u_temp (
    .clk(clk),
    .sys_rst(sys_rst),
    .osr_sel(osr_t),
    .filt_sel(filt_sel),
    .filt_reset(filt_rst_r),
    .update(filt_upd_r),
    .raw_in(raw_t_r),
    .result_r(temp_res)
  ); // [R15] [R10] [R09]

  // Read port: data one cycle after strobe, zero otherwise
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      conv_temp_active <= 1'b0;
      conv_press_active <= 1'b0;
      measuring <= 1'b0;
    end else begin
      conv_temp_active <= (state_r == ST_TEMP) && (osr_t != `OSR_SKIP);
      conv_press_active <= (state_r == ST_PRESS) && (osr_p != `OSR_SKIP);
      measuring <= busy;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_CTRL_MEAS: reg_rdata <= {ctrl_r[7:2], mode_r};
          `ADDR_CONFIG: reg_rdata <= config_r;
          `ADDR_STATUS: reg_rdata <= {4'h0, busy, 2'b00, pend_r};
          `ADDR_PRESS_MSB: reg_rdata <= press_res[19:12];
          `ADDR_PRESS_LSB: reg_rdata <= press_res[11:4];
          `ADDR_PRESS_XLB: reg_rdata <= {press_res[3:0], 4'h0}; // [R06]
          `ADDR_TEMP_MSB: reg_rdata <= temp_res[19:12];
          `ADDR_TEMP_LSB: reg_rdata <= temp_res[11:4];
          `ADDR_TEMP_XLB: reg_rdata <= {temp_res[3:0], 4'h0}; // [R09]
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // pressure_temp_measure_seq
`default_nettype wire

/* inc/ptm_defines.vh */
// Register offsets, reset values, codes and timing constants of the measurement sequencer
`ifndef PTM_DEFINES_VH
`define PTM_DEFINES_VH
`define ADDR_CTRL_MEAS 8'hF4
`define ADDR_CONFIG 8'hF5
`define ADDR_STATUS 8'hF3
`define ADDR_PRESS_MSB 8'hF7
`define ADDR_PRESS_LSB 8'hF8
`define ADDR_PRESS_XLB 8'hF9
`define ADDR_TEMP_MSB 8'hFA
`define ADDR_TEMP_LSB 8'hFB
`define ADDR_TEMP_XLB 8'hFC
`define ADDR_RAW_P_LO 8'hE0
`define ADDR_RAW_P_HI 8'hE1
`define ADDR_RAW_T_LO 8'hE2
`define ADDR_RAW_T_HI 8'hE3
`define CTRL_RST 8'h00
`define CONFIG_RST 8'h00
`define SKIP_VALUE 20'h8_0000
`define MODE_SLEEP 2'b00
`define MODE_NORMAL 2'b11
`define FILT_OFF 3'b000
`define OSR_SKIP 3'b000
`define CONV_BASE_US 2
`define CONV_PER_OSR_US 2
`define STBY_0_US 500
`define STBY_1_US 62500
`define STBY_2_US 125000
`define STBY_3_US 250000
`define STBY_4_US 500000
`define STBY_5_US 1000000
`define STBY_6_US 2000000
`define STBY_7_US 4000000
`define CLK_MHZ 100
`endif

/* rtl/iir_channel.v */
// One channel of oversampled conversion result handling with first-order IIR filter
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defines.vh"
module iir_channel (
  input wire clk,
  input wire sys_rst,
  input wire [2:0] osr_sel,
  input wire [2:0] filt_sel,
  input wire filt_reset,
  input wire update,
  input wire [19:0] raw_in,
  output reg [19:0] result_r
);
  reg [19:0] mem_r;
  reg primed_r;
  reg [2:0] shift;
  reg [2:0] drop;
  reg [19:0] sample;
  reg [24:0] acc;
  reg [24:0] acc_sh;
  reg [19:0] filt_nxt;

  always @* begin
    // Coefficient as a power of two: off,2,4,8, higher codes all 16
    case (filt_sel)
      3'b000: shift = 3'd0;
      3'b001: shift = 3'd1;
      3'b010: shift = 3'd2;
      3'b011: shift = 3'd3;
      default: shift = 3'd4; // [R21] [R12]
    endcase
    // Resolution: x1 16 bits up to x16 20 bits; low unused bits cleared
    case (osr_sel)
      3'b001: drop = 3'd4;
      3'b010: drop = 3'd3;
      3'b011: drop = 3'd2;
      3'b100: drop = 3'd1;
      default: drop = 3'd0; // [R08] [R20]
    endcase
    sample = (raw_in >> drop) << drop; // [R06] [R09]
    // (old*(c-1)+new)/c ; step response reaches 75% in 1/2/5/11/22 samples
    acc = ({5'd0, mem_r} << shift) - {5'd0, mem_r} + {5'd0, sample}; // [R11] [R13]
    filt_nxt = acc[19:0];
    // Quotient of a 20-bit weighted mean always fits back into 20 bits
    acc_sh = acc >> shift;
    if (shift != 3'd0)
      filt_nxt = acc_sh[19:0];
  end

  always @(posedge clk) begin
    if (sys_rst) begin // [R04]
      mem_r <= 20'h0_0000;
      primed_r <= 1'b0;
      result_r <= `SKIP_VALUE;
    end else begin
      if (filt_reset)
        primed_r <= 1'b0; // [R14]
      if (update) begin
        if (osr_sel == `OSR_SKIP) begin
          result_r <= `SKIP_VALUE; // [R07] [R10]
          // Memory kept so re-enable filters against last filtered result
        end else if (!primed_r || filt_reset || shift == 3'd0) begin
          mem_r <= sample; // [R14]
          result_r <= sample;
          primed_r <= 1'b1;
        end else begin
          mem_r <= filt_nxt; // [R16]
          result_r <= filt_nxt;
        end
      end
    end
  end
endmodule // iir_channel
`default_nettype wire

/* bench/ptm_checker_asserts.sv */
// Port checker for the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module ptm_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_temp_active,
  input wire logic conv_press_active,
  input wire logic measuring
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ctl_wr = reg_wr && reg_addr == 8'hF4;
  wire idle = !measuring && !conv_temp_active && !conv_press_active;
  // Mode as last written, so standby repeats are only demanded in normal mode
  reg normal_r;
  always @(posedge clk) begin
    if (sys_rst)
      normal_r <= 1'b0;
    else if (ctl_wr)
      normal_r <= reg_wdata[1:0] == 2'b11;
  end
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> idle && reg_rdata == 8'h00)
    else $error("outputs active after reset");
  chk_conv_overlap: assert property (!(conv_temp_active && conv_press_active))
    else $error("both conversions active");
  chk_press_period: assert property (conv_press_active |-> measuring)
    else $error("pressure conversion outside period");
  chk_temp_period: assert property ($rose(conv_temp_active) |-> ##[0:1] measuring)
    else $error("temperature conversion outside period");
  chk_period_end: assert property ($fell(measuring) |-> idle)
    else $error("conversion left running");
  chk_sleep_quiet: assert property (ctl_wr && reg_wdata[1:0] == 2'b00 && idle |=> !measuring [*8])
    else $error("measuring in sleep");
  chk_forced_start: assert property (ctl_wr && reg_wdata[1] != reg_wdata[0] && idle |-> ##[1:6] measuring)
    else $error("forced period did not start");
  chk_forced_once: assert property ($fell(measuring) && !normal_r |=> !measuring [*8])
    else $error("forced mode measured again");
  chk_normal_loop: assert property ($fell(measuring) && normal_r |-> ##[1:60] measuring)
    else $error("normal mode stopped cycling");
endmodule // ptm_checker
bind pressure_temp_measure_seq ptm_checker ptm_checker_i (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .conv_temp_active(conv_temp_active), .conv_press_active(conv_press_active),
  .measuring(measuring));
`default_nettype wire

/* bench/host_model.sv */
// Host controller model on the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_wdata,
  output var logic reg_wr,
  output var logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse, so nothing leans on stale values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // host_model
`default_nettype wire

/* bench/pressure_temp_measure_seq_tb.sv */
// Testbench for the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module pressure_temp_measure_seq_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  logic reg_wr, reg_rd, conv_temp_active, conv_press_active, measuring;
  logic [19:0] adc_press = 20'h0_0000;
  logic [19:0] adc_temp = 20'h0_0000;
  logic [19:0] v;
  int error_cnt = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  host_model host_model_i (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  pressure_temp_measure_seq #(.STBY_0_CYC(20), .CONV_BASE_CYC(2), .CONV_OSR_CYC(1))
    pressure_temp_measure_seq_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_press(adc_press), .adc_temp(adc_temp), .conv_temp_active(conv_temp_active),
    .conv_press_active(conv_press_active), .measuring(measuring));
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_lvl(input logic l);
    for (int n = 0; n < 100 && measuring !== l; n++)
      @(posedge clk);
    check({19'h0_0000, measuring}, {19'h0_0000, l});
  endtask
  task automatic measure(input logic [7:0] ctrl);
    host_model_i.wr(8'hF4, ctrl);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    repeat (8) @(posedge clk);
  endtask
  // Result bytes are MSB, LSB and the upper nibble of the extra-low byte
  task automatic get_res(input logic [7:0] a, output logic [19:0] r);
    logic [7:0] m, l, x;
    host_model_i.rd(a, m);
    host_model_i.rd(a + 8'h01, l);
    host_model_i.rd(a + 8'h02, x);
    r = {m, l, x[7:4]};
  endtask
  task automatic t_reset();
    get_res(8'hF7, v);
    check(v, 20'h8_0000);
    host_model_i.rd(8'hF4, b);
    check(b, 20'h0_0000);
    host_model_i.wr(8'hF4, 8'h24);
    repeat (40) @(posedge clk);
    check(measuring, 20'h0_0000);
  endtask
  task automatic t_codes();
    int k;
    adc_temp <= 20'hA_5C3E;
    adc_press <= 20'h3_C5A7;
    for (int c = 1; c < 8; c++) begin
      k = (c > 4) ? 4 : c - 1;
      measure({c[2:0], c[2:0], ~c[0], c[0]});
      get_res(8'hFA, v);
      check(v, 20'hA_5C3E & (20'hF_FFFF << (4 - k)));
      get_res(8'hF7, v);
      check(v, 20'h3_C5A7 & (20'hF_FFFF << (4 - k)));
      host_model_i.rd(8'hF4, b);
      check(b, {c[2:0], c[2:0], 2'b00});
    end
    measure(8'h21);
    get_res(8'hF7, v);
    check(v, 20'h8_0000);
    measure(8'h05);
    get_res(8'hFA, v);
    check(v, 20'h8_0000);
  endtask
  task automatic t_filter();
    logic [7:0] cfg [4] = '{8'h04, 8'h08, 8'h0C, 8'h1C};
    logic [19:0] exp [4] = '{20'h1_8000, 20'h1_4000, 20'h1_2000, 20'h1_1000};
    for (int i = 0; i < 4; i++) begin
      host_model_i.wr(8'hF5, cfg[i]);
      adc_press <= 20'h1_0000;
      measure(8'h15);
      get_res(8'hF7, v);
      check(v, 20'h1_0000);
      adc_press <= 20'h2_0000;
      measure(8'h15);
      get_res(8'hF7, v);
      check(v, exp[i]);
    end
    measure(8'h01);
    get_res(8'hF7, v);
    check(v, 20'h8_0000);
    measure(8'h15);
    get_res(8'hF7, v);
    check(v, 20'h1_1F00);
  endtask
  task automatic t_normal();
    host_model_i.wr(8'hF5, 8'h00);
    host_model_i.wr(8'hF4, 8'h27);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    check(measuring, 20'h0_0001);
    host_model_i.wr(8'hF4, 8'h24);
    wait_lvl(1'b0);
    repeat (60) @(posedge clk);
    check(measuring, 20'h0_0000);
  endtask
  initial begin
    #500_000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_codes();
    t_filter();
    t_normal();
    give_verdict();
  end
endmodule // pressure_temp_measure_seq_tb
`default_nettype wire
